//--- core/bsdr_scan.sv
// Contract
// - Data registers change only in data-register states.
// - Decoded instruction selects one data register between TDI and TDO.
// - A one-bit bypass stage shortens the chain to one bit.
// - In shift, boundary cells move one place toward TDO.
// - Each boundary cell has a shift stage and a holding latch.
// - Input cells take the pin and feed the core.
// - Output cells take core logic and feed the pin.
// - A control cell gates the output cell onto its pin.
// - Output without control cell drives its pin except under high-impedance.
// - Bidirectional pins: input cell plus gated output cell.
// - Identification instruction selects and shifts the identification word.
// - Identification word is 32 bits, version in top four.
// - Part number then maker code below the version field.
// - Identification word bit zero is always one.
// - Sample, bypass and identification keep normal pin-core paths.
// - External test, clamp and high-impedance isolate the core.
// - Sample loads pins and core outputs into the boundary chain.
// - External test drives pins from the boundary latches.
// - Clamp holds pins at latches and selects bypass.
// - High-impedance releases all outputs and selects bypass.
// - Bypass instruction selects the bypass stage.
// - An instruction acts as soon as it is stored.
// - Test-logic-reset makes identification the current instruction.
// - Capture loads pins into input cells, core into output cells.
// - Update copies boundary shift stages into their latches.
// - All-ones code decodes as bypass; other unknown codes too.
`timescale 1ns/1ns

// ------------------------------------------------------------------
// Event queue.
// ------------------------------------------------------------------
module bsdr_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  logic             push;
  logic             pop;

  assign out_valid = (wr_reg != rd_reg);
  assign in_ready  = (wr_reg != {~rd_reg[AW], rd_reg[AW-1:0]});
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_reg[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end
endmodule // bsdr_fifo

// ------------------------------------------------------------------
// Data-register side of the test access port.
// ------------------------------------------------------------------
module bsdr_scan (
  input  wire logic                         clk_sys,
  input  wire logic                         sys_rst,
  input  wire logic                         tck,
  input  wire logic                         tdi,
  output logic                              tdo,
  output logic                              tdo_oe,
  input  wire bsdr_pkg::bsdr_tap_t          tap,
  input  wire logic [bsdr_pkg::IR_LEN-1:0]  ir_code,
  input  wire logic                         ir_load,
  input  wire logic                         scan_stall,
  output logic                              evt_ready,
  output logic                              test_mode,
  input  wire logic [bsdr_pkg::NP-1:0]      in_pin,
  output logic      [bsdr_pkg::NP-1:0]      core_in,
  input  wire logic [bsdr_pkg::NP-1:0]      core_tri_o,
  input  wire logic [bsdr_pkg::NP-1:0]      core_tri_oe,
  output logic      [bsdr_pkg::NP-1:0]      tri_o,
  output logic      [bsdr_pkg::NP-1:0]      tri_oe,
  input  wire logic [bsdr_pkg::NP-1:0]      core_plain_o,
  output logic      [bsdr_pkg::NP-1:0]      plain_o,
  output logic      [bsdr_pkg::NP-1:0]      plain_oe,
  input  wire logic [bsdr_pkg::NP-1:0]      bidi_i,
  output logic      [bsdr_pkg::NP-1:0]      core_bidi_in,
  input  wire logic [bsdr_pkg::NP-1:0]      core_bidi_o,
  input  wire logic [bsdr_pkg::NP-1:0]      core_bidi_oe,
  output logic      [bsdr_pkg::NP-1:0]      bidi_o,
  output logic      [bsdr_pkg::NP-1:0]      bidi_oe
);
  localparam int NP = bsdr_pkg::NP;
  localparam int BL = bsdr_pkg::BSR_LEN;
  localparam int IL = bsdr_pkg::ID_LEN;
  localparam int SW = 2 + 2 * NP;
  localparam int CI_IN  = bsdr_pkg::CI_IN,  CI_BIN = bsdr_pkg::CI_BIN;
  localparam int CI_TRO = bsdr_pkg::CI_TRO, CI_TRC = bsdr_pkg::CI_TRC;
  localparam int CI_PLO = bsdr_pkg::CI_PLO, CI_BIO = bsdr_pkg::CI_BIO;
  localparam int CI_BIC = bsdr_pkg::CI_BIC;
  logic [SW-1:0]          s1_reg;
  logic [SW-1:0]          s2_reg;
  logic                   tck_d_reg;
  logic                   tck_s;
  logic                   tdi_s;
  logic [NP-1:0]          in_s;
  logic [NP-1:0]          bidi_s;
  logic                   tck_rise;
  logic                   tck_fall;
  bsdr_pkg::bsdr_evt_t    evt_in;
  bsdr_pkg::bsdr_evt_t    evt;
  logic                   evt_valid;
  logic                   pop;
  bsdr_pkg::bsdr_instr_t  instr_reg;
  bsdr_pkg::bsdr_sel_t    sel;
  logic                   pins_lat;
  logic                   highz;
  logic                   byp_reg;
  logic [IL-1:0]          id_reg;
  logic [BL-1:0]          cap_src;
  logic [BL-1:0]          bsr_sh;
  logic [BL-1:0]          bsr_lat;

  // ----------------------------------------------------------------
  // Pin synchronisers and link clock edges.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      tck_d_reg <= 1'b0;
    end else begin
      s1_reg    <= {tck, tdi, in_pin, bidi_i};
      s2_reg    <= s1_reg;
      tck_d_reg <= tck_s;
    end
  end

  assign {tck_s, tdi_s, in_s, bidi_s} = s2_reg;
  assign tck_rise = tck_s && !tck_d_reg;
  assign tck_fall = !tck_s && tck_d_reg;

  // ----------------------------------------------------------------
  // Each rising link edge queues one data-register event unless the queue is full.
  // ----------------------------------------------------------------
  assign evt_in = '{capture: tap.capture_dr, shift: tap.shift_dr,
                    update: tap.update_dr, tdi: tdi_s};
  assign pop    = evt_valid && !scan_stall;

  bsdr_fifo #(
    .WIDTH (bsdr_pkg::EVT_W),
    .DEPTH (bsdr_pkg::FIFO_DEP),
    .AW    (bsdr_pkg::FIFO_AW)
  ) u_evt_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_valid  (tck_rise),
    .in_ready  (evt_ready),
    .in_data   (evt_in),
    .out_valid (evt_valid),
    .out_ready (!scan_stall),
    .out_data  (evt)
  );

  // ----------------------------------------------------------------
  // Instruction decode and register selection.
  // ----------------------------------------------------------------
  function automatic bsdr_pkg::bsdr_instr_t decode(
    input logic [bsdr_pkg::IR_LEN-1:0] code);
    case (code)
      bsdr_pkg::OP_SAMPLE: decode = bsdr_pkg::INS_SAMPLE;
      bsdr_pkg::OP_EXTEST: decode = bsdr_pkg::INS_EXTEST;
      bsdr_pkg::OP_IDCODE: decode = bsdr_pkg::INS_IDCODE;
      bsdr_pkg::OP_CLAMP:  decode = bsdr_pkg::INS_CLAMP;
      bsdr_pkg::OP_HIGHZ:  decode = bsdr_pkg::INS_HIGHZ;
      default:             decode = bsdr_pkg::INS_BYPASS;
    endcase
  endfunction

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      instr_reg <= bsdr_pkg::INS_IDCODE;
    end else if (tap.logic_reset) begin
      instr_reg <= bsdr_pkg::INS_IDCODE;
    end else if (ir_load) begin
      instr_reg <= decode(ir_code);
    end
  end

  always_comb begin
    case (instr_reg)
      bsdr_pkg::INS_SAMPLE: sel = bsdr_pkg::SEL_BSR;
      bsdr_pkg::INS_EXTEST: sel = bsdr_pkg::SEL_BSR;
      bsdr_pkg::INS_IDCODE: sel = bsdr_pkg::SEL_ID;
      default:              sel = bsdr_pkg::SEL_BYP;
    endcase
  end

  assign pins_lat  = (instr_reg == bsdr_pkg::INS_EXTEST) ||
                     (instr_reg == bsdr_pkg::INS_CLAMP);
  assign highz     = (instr_reg == bsdr_pkg::INS_HIGHZ);
  assign test_mode = pins_lat || highz;

  // ----------------------------------------------------------------
  // Bypass and identification registers.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      byp_reg <= 1'b0;
    end else if (pop && sel == bsdr_pkg::SEL_BYP) begin
      if (evt.capture) begin
        byp_reg <= 1'b0;
      end else if (evt.shift) begin
        byp_reg <= evt.tdi;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      id_reg <= '0;
    end else if (pop && sel == bsdr_pkg::SEL_ID) begin
      if (evt.capture) begin
        id_reg <= bsdr_pkg::ID_WORD;
      end else if (evt.shift) begin
        id_reg <= {evt.tdi, id_reg[IL-1:1]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Boundary cells, bit 0 at the output end.
  // ----------------------------------------------------------------
  assign cap_src = {core_bidi_oe, core_bidi_o, core_plain_o, core_tri_oe,
                    core_tri_o, bidi_s, in_s};

  for (genvar i = 0; i < BL; i++) begin : g_cell
    logic sh_reg;
    logic lat_reg;
    logic sin;

    if (i == BL - 1) begin : g_top
      assign sin = evt.tdi;
    end else begin : g_mid
      assign sin = bsr_sh[i+1];
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        sh_reg <= 1'b0;
      end else if (pop && sel == bsdr_pkg::SEL_BSR) begin
        if (evt.capture) begin
          sh_reg <= cap_src[i];
        end else if (evt.shift) begin
          sh_reg <= sin;
        end
      end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        lat_reg <= 1'b0;
      end else if (pop && evt.update && sel == bsdr_pkg::SEL_BSR) begin
        lat_reg <= sh_reg;
      end
    end

    assign bsr_sh[i]  = sh_reg;
    assign bsr_lat[i] = lat_reg;
  end

  // ----------------------------------------------------------------
  // Serial output, changed on falling link edges.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe <= tap.shift_dr;
      case (sel)
        bsdr_pkg::SEL_BSR: tdo <= bsr_sh[0];
        bsdr_pkg::SEL_ID:  tdo <= id_reg[0];
        default:           tdo <= byp_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin and core paths.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      core_in      <= '0;
      core_bidi_in <= '0;
      tri_o        <= '0;
      tri_oe       <= '0;
      plain_o      <= '0;
      plain_oe     <= '0;
      bidi_o       <= '0;
      bidi_oe      <= '0;
    end else begin
      core_in      <= test_mode ? bsr_lat[CI_IN+:NP] : in_s;
      core_bidi_in <= test_mode ? bsr_lat[CI_BIN+:NP] : bidi_s;
      tri_o   <= pins_lat ? bsr_lat[CI_TRO+:NP] : core_tri_o;
      plain_o <= pins_lat ? bsr_lat[CI_PLO+:NP] : core_plain_o;
      bidi_o  <= pins_lat ? bsr_lat[CI_BIO+:NP] : core_bidi_o;
      tri_oe  <= highz ? '0 :
                 (pins_lat ? bsr_lat[CI_TRC+:NP] : core_tri_oe);
      plain_oe <= highz ? '0 : '1;
      bidi_oe <= highz ? '0 :
                 (pins_lat ? bsr_lat[CI_BIC+:NP] : core_bidi_oe);
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_shift(bsdr_pkg::bsdr_sel_t s);
    pop && evt.shift && !evt.capture && sel == s;
  endsequence

  sequence s_capture(bsdr_pkg::bsdr_sel_t s);
    pop && evt.capture && sel == s;
  endsequence

  chk_bypass_capt: assert property (
    s_capture(bsdr_pkg::SEL_BYP) |=> !byp_reg)
    else $error("Bypass stage did not capture zero.");

  chk_bypass_path: assert property (
    s_shift(bsdr_pkg::SEL_BYP) |=> byp_reg == $past(evt.tdi))
    else $error("Bypass stage did not take the serial input.");

  chk_id_capture: assert property (
    s_capture(bsdr_pkg::SEL_ID) |=> id_reg[0] && id_reg[31:28] ==
      bsdr_pkg::ID_VERSION)
    else $error("Identification word captured wrongly.");

  chk_bsr_shift: assert property (
    s_shift(bsdr_pkg::SEL_BSR) |=>
      bsr_sh == {$past(evt.tdi), $past(bsr_sh[BL-1:1])})
    else $error("Boundary chain did not move one place.");

  chk_bsr_update: assert property (
    pop && evt.update && sel == bsdr_pkg::SEL_BSR |=>
      bsr_lat == $past(bsr_sh))
    else $error("Boundary latches not updated.");

  chk_idle_hold: assert property (
    !pop |=> $stable(bsr_sh) && $stable(bsr_lat) && $stable(id_reg)
      && $stable(byp_reg))
    else $error("Data registers changed without an event.");

  chk_reset_instr: assert property (
    tap.logic_reset |=> instr_reg == bsdr_pkg::INS_IDCODE)
    else $error("Reset state did not select identification.");

  chk_instr_load: assert property (
    ir_load && !tap.logic_reset && ir_code == bsdr_pkg::OP_BYPASS |=>
      sel == bsdr_pkg::SEL_BYP)
    else $error("All-ones code did not select bypass.");

  chk_highz_pins: assert property (
    highz ##1 highz |-> tri_oe == '0 && bidi_oe == '0 && plain_oe == '0)
    else $error("Outputs driven under high impedance.");

  chk_normal_path: assert property (
    !test_mode |=> core_in == $past(in_s) && tri_o == $past(core_tri_o))
    else $error("Normal path broken in normal mode.");

  chk_extest_pins: assert property (
    pins_lat |=> tri_o == $past(bsr_lat[CI_TRO+:NP]))
    else $error("Pins not driven from latches.");

endmodule // bsdr_scan

//--- core/bsdr_pkg.sv
package bsdr_pkg;

  // ----------------------------------------------------------------
  // Sizes and cell positions in the boundary chain.
  // ----------------------------------------------------------------
  localparam int IR_LEN   = 8;
  localparam int NP       = 2;
  localparam int CI_IN    = 0;
  localparam int CI_BIN   = 2;
  localparam int CI_TRO   = 4;
  localparam int CI_TRC   = 6;
  localparam int CI_PLO   = 8;
  localparam int CI_BIO   = 10;
  localparam int CI_BIC   = 12;
  localparam int BSR_LEN  = 14;
  localparam int ID_LEN   = 32;
  localparam int EVT_W    = 4;
  localparam int FIFO_DEP = 8;
  localparam int FIFO_AW  = 3;

  // ----------------------------------------------------------------
  // Instruction codes.
  // ----------------------------------------------------------------
  localparam logic [IR_LEN-1:0] OP_EXTEST = 8'h00;
  localparam logic [IR_LEN-1:0] OP_IDCODE = 8'h01;
  localparam logic [IR_LEN-1:0] OP_SAMPLE = 8'h02;
  localparam logic [IR_LEN-1:0] OP_CLAMP  = 8'h03;
  localparam logic [IR_LEN-1:0] OP_HIGHZ  = 8'h04;
  localparam logic [IR_LEN-1:0] OP_BYPASS = 8'hff;

  // ----------------------------------------------------------------
  // Identification word; field values are arbitrary.
  // ----------------------------------------------------------------
  localparam logic [3:0]  ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART    = 16'h0001;
  localparam logic [10:0] ID_MAKER   = 11'h001;
  localparam logic        ID_FIXED   = 1'b1;
  localparam logic [ID_LEN-1:0] ID_WORD =
    {ID_VERSION, ID_PART, ID_MAKER, ID_FIXED};

  // ----------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    INS_BYPASS = 6'h01,
    INS_SAMPLE = 6'h02,
    INS_EXTEST = 6'h04,
    INS_IDCODE = 6'h08,
    INS_CLAMP  = 6'h10,
    INS_HIGHZ  = 6'h20
  } bsdr_instr_t;

  typedef enum logic [2:0] {
    SEL_BYP = 3'h1,
    SEL_BSR = 3'h2,
    SEL_ID  = 3'h4
  } bsdr_sel_t;

  typedef struct packed {
    logic logic_reset;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
  } bsdr_tap_t;

  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
    logic tdi;
  } bsdr_evt_t;

endpackage

//--- tb/bsdr_host_model.sv
`timescale 1ns/1ns

// ----------------------------------------
// Test controller on the far side of the scan port.
// ----------------------------------------
module bsdr_host_model (
  input  wire logic           clk_sys,
  input  wire logic           tdo,
  input  wire logic           tdo_oe,
  output logic                tck,
  output logic                tdi,
  output bsdr_pkg::bsdr_tap_t tap
);
  initial begin
    tck = 1'b0;
    tdi = 1'b0;
    tap = 4'h0;
  end

  // One link clock period of 10 system clocks; the output is sampled
  // just before the rise and the input is let go after the fall.
  // An undriven output line reads as the inverse of its last level.
  task automatic cycle(input bsdr_pkg::bsdr_tap_t f, input logic d,
                       output logic q);
    @(negedge clk_sys);
    tap = f;
    tdi = d;
    repeat (4) @(negedge clk_sys);
    q = tdo_oe ? tdo : ~tdo;
    tck = 1'b1;
    repeat (5) @(negedge clk_sys);
    tck = 1'b0;
    tdi = ~d;
  endtask
endmodule // bsdr_host_model

//--- tb/tb_top.sv
`timescale 1ns/1ns

module tb_top;
  localparam bsdr_pkg::bsdr_tap_t T_IDLE = 4'h0;
  localparam bsdr_pkg::bsdr_tap_t T_UPD  = 4'h1;
  localparam bsdr_pkg::bsdr_tap_t T_SHF  = 4'h2;
  localparam bsdr_pkg::bsdr_tap_t T_CAP  = 4'h4;
  localparam bsdr_pkg::bsdr_tap_t T_TLR  = 4'h8;
  localparam logic [13:0] PAT = 14'h2d76;
  localparam logic [1:0]  EXT = 2'h3;

  logic                              clk_sys, sys_rst, tck, tdi, tdo;
  logic                              tdo_oe, ir_load, scan_stall;
  logic                              evt_ready, test_mode;
  bsdr_pkg::bsdr_tap_t               tap;
  logic [bsdr_pkg::IR_LEN-1:0]       ir_code;
  logic [1:0]                        in_pin, core_in, core_tri_o, tri_o;
  logic [1:0]                        core_tri_oe, tri_oe, core_plain_o;
  logic [1:0]                        plain_o, plain_oe, bidi_i, bidi_o;
  logic [1:0]                        core_bidi_in, core_bidi_o, bidi_oe;
  logic [1:0]                        core_bidi_oe;
  int                                mismatches, comparisons;

  // Level of the two-way pins: the board pulls where nobody drives.
  assign bidi_i = (bidi_oe & bidi_o) | (~bidi_oe & EXT);

  bsdr_scan u_bsdr_scan (.clk_sys(clk_sys), .sys_rst(sys_rst), .tck(tck),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .tap(tap), .ir_code(ir_code),
    .ir_load(ir_load), .scan_stall(scan_stall), .evt_ready(evt_ready),
    .test_mode(test_mode), .in_pin(in_pin), .core_in(core_in),
    .core_tri_o(core_tri_o), .core_tri_oe(core_tri_oe), .tri_o(tri_o),
    .tri_oe(tri_oe), .core_plain_o(core_plain_o), .plain_o(plain_o),
    .plain_oe(plain_oe), .bidi_i(bidi_i), .core_bidi_in(core_bidi_in),
    .core_bidi_o(core_bidi_o), .core_bidi_oe(core_bidi_oe),
    .bidi_o(bidi_o), .bidi_oe(bidi_oe));

  bsdr_host_model u_bsdr_host_model (.clk_sys(clk_sys), .tdo(tdo),
    .tdo_oe(tdo_oe), .tck(tck), .tdi(tdi), .tap(tap));

  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;

  // ----------------------------------------
  // Shared tasks.
  // ----------------------------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic load(logic [7:0] c);
    @(negedge clk_sys);
    ir_code = c;
    ir_load = 1'b1;
    @(negedge clk_sys);
    ir_load = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic step(bsdr_pkg::bsdr_tap_t f);
    logic q;
    u_bsdr_host_model.cycle(f, 1'b0, q);
  endtask

  task automatic scan(int n, logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = 32'h0;
    for (int i = 0; i < n; i++) begin
      u_bsdr_host_model.cycle(T_SHF, din[i], q);
      dout[i] = q;
    end
  endtask

  task automatic check_pins(logic hz);
    logic [1:0] toe, poe, boe;
    toe = hz ? 2'h0 : PAT[7:6];
    poe = hz ? 2'h0 : 2'h3;
    boe = hz ? 2'h0 : PAT[13:12];
    check("test_mode", test_mode, 1'b1);
    check("core_in", core_in, PAT[1:0]);
    check("core_bidi_in", core_bidi_in, PAT[3:2]);
    check("tri_oe", tri_oe, toe);
    check("tri_o", tri_o & toe, PAT[5:4] & toe);
    check("plain_oe", plain_oe, poe);
    check("plain_o", plain_o & poe, PAT[9:8] & poe);
    check("bidi_oe", bidi_oe, boe);
    check("bidi_o", bidi_o & boe, PAT[11:10] & boe);
  endtask

  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task automatic test_reset;
    logic [31:0] d;
    check("test_mode", test_mode, 1'b0);
    check("plain_oe", plain_oe, 2'h3);
    step(T_CAP);
    scan(32, 32'h0, d);
    check("idcode", d, bsdr_pkg::ID_WORD);
    check("id_fixed", d[0], 1'b1);
    check("id_version", d[31:28], bsdr_pkg::ID_VERSION);
    check("id_part", d[27:12], bsdr_pkg::ID_PART);
    check("id_maker", d[11:1], bsdr_pkg::ID_MAKER);
    $display("test_reset done");
  endtask

  task automatic test_tlr;
    logic [31:0] a, b;
    load(bsdr_pkg::OP_SAMPLE);
    step(T_TLR);
    step(T_CAP);
    scan(4, 32'h0, a);
    step(T_IDLE);
    step(T_UPD);
    scan(28, 32'h0, b);
    check("id_paused", {b[27:0], a[3:0]},
          bsdr_pkg::ID_WORD);
    $display("test_tlr done");
  endtask

  task automatic test_bypass;
    logic [31:0] d;
    logic [7:0] codes [2];
    codes = '{bsdr_pkg::OP_BYPASS, 8'h55};
    for (int k = 0; k < 2; k++) begin
      load(codes[k]);
      check("test_mode", test_mode, 1'b0);
      step(T_CAP);
      scan(8, 32'hb5, d);
      check("bypass", d[7:0], 8'h6a);
      repeat (4) @(negedge clk_sys);
      check("tdo_oe", tdo_oe, 1'b1);
    end
    $display("test_bypass done");
  endtask

  task automatic test_fifo;
    logic q;
    load(bsdr_pkg::OP_BYPASS);
    scan_stall = 1'b1;
    for (int i = 0; i < 8; i++) begin
      u_bsdr_host_model.cycle(T_SHF, i[0], q);
    end
    check("evt_ready_full", evt_ready, 1'b0);
    u_bsdr_host_model.cycle(T_SHF, 1'b0, q);
    @(negedge clk_sys);
    scan_stall = 1'b0;
    repeat (20) @(negedge clk_sys);
    check("evt_ready_empty", evt_ready, 1'b1);
    step(T_UPD);
    u_bsdr_host_model.cycle(T_SHF, 1'b0, q);
    check("bypass_drained", q, 1'b1);
    $display("test_fifo done");
  endtask

  task automatic test_sample;
    logic [31:0] d, e;
    logic [1:0] bw;
    bw = (core_bidi_oe & core_bidi_o) | (~core_bidi_oe & EXT);
    e = {core_bidi_oe, core_bidi_o, core_plain_o, core_tri_oe,
         core_tri_o, bw, in_pin};
    load(bsdr_pkg::OP_SAMPLE);
    repeat (4) @(negedge clk_sys);
    check("core_in", core_in, in_pin);
    check("core_bidi_in", core_bidi_in, bw);
    check("tri_o", tri_o, core_tri_o);
    check("tri_oe", tri_oe, core_tri_oe);
    check("bidi_oe", bidi_oe, core_bidi_oe);
    step(T_CAP);
    scan(14, {18'h0, PAT}, d);
    check("chain", d, e);
    step(T_UPD);
    repeat (4) @(negedge clk_sys);
    check("plain_o", plain_o, core_plain_o);
    $display("test_sample done");
  endtask

  task automatic test_extest;
    load(bsdr_pkg::OP_EXTEST);
    check_pins(1'b0);
    @(negedge clk_sys);
    in_pin = ~in_pin;
    repeat (6) @(negedge clk_sys);
    check("core_in_isolated", core_in, PAT[1:0]);
    in_pin = ~in_pin;
    $display("test_extest done");
  endtask

  task automatic test_clamp_highz;
    logic [31:0] d;
    for (int k = 0; k < 2; k++) begin
      load(k == 1 ? bsdr_pkg::OP_HIGHZ : bsdr_pkg::OP_CLAMP);
      check_pins(k[0]);
      step(T_CAP);
      scan(2, 32'h1, d);
      check("bypass_test", d[1:0], 2'h2);
    end
    $display("test_clamp_highz done");
  endtask

  initial begin
    mismatches = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    ir_code = 8'h0;
    ir_load = 1'b0;
    scan_stall = 1'b0;
    in_pin = 2'h1;
    core_tri_o = 2'h3;
    core_tri_oe = 2'h1;
    core_plain_o = 2'h2;
    core_bidi_o = 2'h1;
    core_bidi_oe = 2'h2;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    test_reset();
    test_tlr();
    test_bypass();
    test_fifo();
    test_sample();
    test_extest();
    test_clamp_highz();
    results();
  end

  initial begin
    #400000;
    mismatches++;
    results();
  end
endmodule // tb_top
